// *** hdl/cpw_channel.sv ***
// Purpose: One PWM channel with its 16-bit up/down timer counter.
// Assumes: Register port on the bus clock; reads answer one cycle later.
// Notes: Output level lives in one flip-flop changed only by compares.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// RQ1: Center mode, channel equal to modulo holds output active: full duty.
// RQ2: Channel value with top bit set keeps output inactive all period.
// RQ3: Center mode, channel one below modulo gives near-full duty.
// RQ4: Center mode, new channel value waits for next period start.
// RQ5: Change to zero while counting up finishes period with old value.
// RQ6: Center mode period starts with down-count half, then up-count.
// RQ7: Center pulse lasts twice channel value; change from zero waits.
// RQ8: Edge mode, zero to nonzero adds one more empty period.
// RQ9: Prescale divider not cleared when prescale setting changes.
// RQ10: Prescale select pattern 0:0:1 divides the timer clock by two.
// RQ11: Software bumps channel equal to modulo, for modulo below 0x7FFF.
// RQ12: Software writes a negative value rather than zero for 0% duty.
// RQ13: Software may halve prescale, double modulo and channel values.
// RQ14: Center counter runs up to modulo, down to zero; period doubles.
// RQ15: Output flip-flop cleared at reset, changed only by compare events.
// RQ16: Counter reset leaves direction alone; may count down from zero.
// RQ17: Channel and modulo held as byte pairs, compared every tick.
module cpw_channel
    import cpw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic pwm_out
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] cnt;
        logic dir_down;
        logic [15:0] ch_eff;
        logic out;
        logic [7:0] rdata;
    } cpw_chan_state_t;

    cpw_chan_state_t s;
    cpw_chan_state_t next_s;

    logic [15:0] modulo_pair;
    logic [15:0] channel_value_pair;
    logic [2:0] prescale_select;
    logic [1:0] clock_source_select;
    logic center;
    logic run;
    logic tick;

    assign prescale_select = s.ctrl[CPW_CTRL_PS_LSB +: 3];
    assign clock_source_select = s.ctrl[CPW_CTRL_CS_LSB +: 2];
    assign center = s.ctrl[CPW_CTRL_CENTER];
    // Any non-zero source selection starts the counter
    assign run = (clock_source_select != 2'b00);

    assign rd_data = s.rdata;
    assign pwm_out = s.out;

    cpw_byte_pair u_modulo (
        .clock(clock),
        .rst(rst),
        .wr_hi(wr_en && (addr == CPW_ADDR_MOD_H)),
        .wr_lo(wr_en && (addr == CPW_ADDR_MOD_L)),
        .wdata(wr_data),
        .value(modulo_pair)
    );

    cpw_byte_pair u_channel (
        .clock(clock),
        .rst(rst),
        .wr_hi(wr_en && (addr == CPW_ADDR_CHV_H)),
        .wr_lo(wr_en && (addr == CPW_ADDR_CHV_L)),
        .wdata(wr_data),
        .value(channel_value_pair)
    );

    cpw_prescaler u_prescaler (
        .clock(clock),
        .rst(rst),
        .run(run),
        .prescale_select(prescale_select),
        .tick(tick)
    );

    always_comb begin
        logic [15:0] top;
        logic [15:0] cnt_n;
        logic dir_n;
        logic start;
        logic [15:0] ch_n;
        logic neg;

        top = CPW_FULL_RANGE;
        cnt_n = s.cnt;
        dir_n = s.dir_down;
        start = 1'b0;
        ch_n = s.ch_eff;
        neg = 1'b0;
        next_s = s;
        next_s.rdata = 8'h00;

        if (modulo_pair != 16'h0000) begin
            top = modulo_pair;
        end

        if (wr_en && (addr == CPW_ADDR_CTRL)) begin
            next_s.ctrl = wr_data & CPW_CTRL_MASK;
        end

        if (rd_en) begin
            case (addr)
                CPW_ADDR_CTRL: begin
                    next_s.rdata = s.ctrl;
                end
                CPW_ADDR_CNT_H: begin
                    next_s.rdata = s.cnt[15:8];
                end
                CPW_ADDR_CNT_L: begin
                    next_s.rdata = s.cnt[7:0];
                end
                CPW_ADDR_MOD_H: begin
                    next_s.rdata = modulo_pair[15:8];
                end
                CPW_ADDR_MOD_L: begin
                    next_s.rdata = modulo_pair[7:0];
                end
                CPW_ADDR_CHV_H: begin
                    next_s.rdata = channel_value_pair[15:8];
                end
                CPW_ADDR_CHV_L: begin
                    next_s.rdata = channel_value_pair[7:0];
                end
                CPW_ADDR_STATUS: begin
                    next_s.rdata[CPW_STAT_DIR] = s.dir_down;
                    next_s.rdata[CPW_STAT_OUT] = s.out;
                    next_s.rdata[CPW_STAT_CENTER] = center;
                    next_s.rdata[CPW_STAT_RUN] = run;
                end
                CPW_ADDR_CHE_H: begin
                    next_s.rdata = s.ch_eff[15:8];
                end
                CPW_ADDR_CHE_L: begin
                    next_s.rdata = s.ch_eff[7:0];
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        if (tick && center) begin
            // RQ14 up then down
            if (s.dir_down) begin
                cnt_n = s.cnt - 16'h0001;
            end else begin
                cnt_n = s.cnt + 16'h0001;
            end
            // RQ6 period opens at top
            if (!s.dir_down && (cnt_n == top)) begin
                dir_n = 1'b1;
                start = 1'b1;
            end
            if (s.dir_down && (cnt_n == 16'h0000)) begin
                dir_n = 1'b0;
            end

            // RQ4 load only at start
            // RQ5 old value kept mid-period
            if (start) begin
                ch_n = channel_value_pair;
            end
            neg = ch_n[15];

            if (start) begin
                // RQ2 negative forces inactive
                if (neg) begin
                    next_s.out = 1'b0;
                // RQ1 full duty at modulo
                end else if (ch_n >= top) begin
                    next_s.out = 1'b1;
                end
            end

            // RQ7 set going down, clear going up
            // RQ3 modulo minus one still matches
            // RQ15 level moves on compare only
            if (!neg && (cnt_n == ch_n)) begin
                next_s.out = dir_n;
            end

            next_s.cnt = cnt_n;
            next_s.dir_down = dir_n;
            next_s.ch_eff = ch_n;
        end else if (tick) begin
            if (s.cnt == top) begin
                start = 1'b1;
                cnt_n = 16'h0000;
            end else begin
                cnt_n = s.cnt + 16'h0001;
            end

            if (start) begin
                next_s.ch_eff = channel_value_pair;
                // RQ8 late update gives empty period
                if ((s.ch_eff == 16'h0000) && (channel_value_pair != 16'h0000)
                    && !channel_value_pair[15]) begin
                    next_s.out = 1'b0;
                // RQ2 negative forces inactive
                end else if (channel_value_pair[15]) begin
                    next_s.out = 1'b0;
                end else begin
                    next_s.out = (channel_value_pair != 16'h0000);
                end
            // RQ15 clear on channel match
            end else if (!s.ch_eff[15] && (cnt_n == s.ch_eff)) begin
                next_s.out = 1'b0;
            end

            next_s.cnt = cnt_n;
        end

        // RQ16 counter cleared, direction kept
        if (wr_en && ((addr == CPW_ADDR_CNT_H)
            || (addr == CPW_ADDR_CNT_L))) begin
            next_s.cnt = CPW_CNT_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s.ctrl <= CPW_CTRL_RESET;
            s.cnt <= CPW_CNT_RESET;
            s.dir_down <= 1'b0;
            s.ch_eff <= CPW_PAIR_RESET;
            s.out <= 1'b0;
            s.rdata <= 8'h00;
        end else begin
            s <= next_s;
        end
    end

endmodule : cpw_channel

// *** hdl/cpw_pkg.sv ***
// Purpose: Shared constants for the center/edge PWM channel.
// Assumes: 8-bit register port, 16-bit counter, one 20 MHz clock.
// Notes: Byte offsets index an 8-bit register space of sixteen slots.
package cpw_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] CPW_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CPW_ADDR_CNT_H = 4'h1;
    localparam logic [3:0] CPW_ADDR_CNT_L = 4'h2;
    localparam logic [3:0] CPW_ADDR_MOD_H = 4'h3;
    localparam logic [3:0] CPW_ADDR_MOD_L = 4'h4;
    localparam logic [3:0] CPW_ADDR_CHV_H = 4'h5;
    localparam logic [3:0] CPW_ADDR_CHV_L = 4'h6;
    localparam logic [3:0] CPW_ADDR_STATUS = 4'h7;
    localparam logic [3:0] CPW_ADDR_CHE_H = 4'h8;
    localparam logic [3:0] CPW_ADDR_CHE_L = 4'h9;

    // Control field positions
    localparam int CPW_CTRL_PS_LSB = 0;
    localparam int CPW_CTRL_CS_LSB = 3;
    localparam int CPW_CTRL_CENTER = 5;
    localparam logic [7:0] CPW_CTRL_MASK = 8'h3F;

    // Status field positions
    localparam int CPW_STAT_DIR = 0;
    localparam int CPW_STAT_OUT = 1;
    localparam int CPW_STAT_CENTER = 2;
    localparam int CPW_STAT_RUN = 3;

    // Values after reset
    localparam logic [7:0] CPW_CTRL_RESET = 8'h00;
    localparam logic [15:0] CPW_CNT_RESET = 16'h0000;
    localparam logic [15:0] CPW_PAIR_RESET = 16'h0000;
    localparam logic [6:0] CPW_DIV_RESET = 7'h00;

    // Modulo of zero lets the counter run the full 16-bit range
    localparam logic [15:0] CPW_FULL_RANGE = 16'hFFFF;

endpackage : cpw_pkg

// *** hdl/cpw_prescaler.sv ***
// Purpose: Divides the bus clock into a one-cycle timer tick.
// Assumes: run and prescale_select come from logic on the same clock.
// Notes: Divider state survives a change of division on purpose.
`timescale 1ns/1ps

module cpw_prescaler
    import cpw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] prescale_select,
    output logic tick
);

    typedef struct packed {
        logic [6:0] div;
    } cpw_div_state_t;

    cpw_div_state_t s;
    cpw_div_state_t next_s;
    logic [7:0] span;
    logic [6:0] mask;

    // RQ10 divide by power of two
    assign span = 8'h01 << prescale_select;
    assign mask = 7'(span - 8'h01);
    assign tick = run && ((s.div & mask) == mask);

    always_comb begin
        next_s = s;
        // RQ9 divider cleared only by reset
        if (run) begin
            next_s.div = s.div + 7'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s.div <= CPW_DIV_RESET;
        end else begin
            s <= next_s;
        end
    end

endmodule : cpw_prescaler

// *** hdl/cpw_byte_pair.sv ***
// Purpose: Holds one 16-bit setting written as two byte halves.
// Assumes: Each half is written by its own one-cycle strobe.
// Notes: No coherency latch; software writes high then low.
`timescale 1ns/1ps

module cpw_byte_pair
    import cpw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [7:0] wdata,
    output logic [15:0] value
);

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } cpw_pair_state_t;

    cpw_pair_state_t s;
    cpw_pair_state_t next_s;

    assign value = {s.hi, s.lo};

    always_comb begin
        next_s = s;
        // RQ17 byte halves kept
        if (wr_hi) begin
            next_s.hi = wdata;
        end
        if (wr_lo) begin
            next_s.lo = wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= CPW_PAIR_RESET;
        end else begin
            s <= next_s;
        end
    end

endmodule : cpw_byte_pair

// *** tb/cpw_pwm_load.sv ***
// Purpose: Load on the PWM pin; tallies bus cycles spent high.
// Assumes: Pin sampled on the bus clock.
// Notes: Bench clears the tally before each window.
`timescale 1ns/1ps

module cpw_pwm_load (
    input wire logic clock,
    input wire logic clear,
    input wire logic pwm_in,
    output logic [15:0] high_count
);
    always_ff @(posedge clock) begin
        if (clear) begin
            high_count <= 16'h0000;
        end else begin
            high_count <= high_count + {15'h0000, pwm_in};
        end
    end
endmodule : cpw_pwm_load

// *** tb/cpw_channel_checker.sv ***
// Purpose: Port-level checks on the PWM channel.
// Assumes: Only top ports visible; control is shadowed from writes.
// Notes: Counter-clear check needs the counter stopped.
`timescale 1ns/1ps

module cpw_channel_checker
    import cpw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic pwm_out
);
    logic [7:0] ctrl;
    logic cleared;
    wire logic stopped = (ctrl[4:3] == 2'h0);
    wire logic rd_cnt = rd_en && (addr == CPW_ADDR_CNT_H
        || addr == CPW_ADDR_CNT_L);

    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= CPW_CTRL_RESET;
            cleared <= 1'b0;
        end else if (wr_en && addr == CPW_ADDR_CTRL) begin
            ctrl <= wr_data & CPW_CTRL_MASK;
            cleared <= 1'b0;
        end else if (wr_en && (addr == CPW_ADDR_CNT_H
            || addr == CPW_ADDR_CNT_L)) begin
            cleared <= stopped;
        end
    end

    a_read_idle: assert property (
        !$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_zero: assert property (
        rd_en && addr >= 4'hA |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_read: assert property (
        rd_en && addr == CPW_ADDR_CTRL |=> rd_data == $past(ctrl))
        else $error("control readback wrong");
    a_stat_pin: assert property (
        rd_en && addr == CPW_ADDR_STATUS
        |=> rd_data[CPW_STAT_OUT] == $past(pwm_out))
        else $error("status pin bit wrong");
    a_stat_mode: assert property (
        rd_en && addr == CPW_ADDR_STATUS
        |=> rd_data[CPW_STAT_CENTER] == $past(ctrl[CPW_CTRL_CENTER]))
        else $error("status center bit wrong");
    a_stop_hold: assert property (
        $past(stopped) && stopped |-> $stable(pwm_out))
        else $error("pin moved while stopped");
    a_cnt_clear: assert property (
        rd_cnt && cleared && stopped |=> rd_data == 8'h00)
        else $error("counter not cleared by write");
    a_reset_low: assert property (disable iff (1'b0)
        rst |=> !pwm_out && rd_data == 8'h00)
        else $error("reset left outputs set");
endmodule : cpw_channel_checker

bind cpw_channel cpw_channel_checker u_chk (.clock(clock), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .pwm_out(pwm_out));

// *** tb/tb_center_edge_pwm_channel.sv ***
// Purpose: Directed register-port tests of the PWM channel.
// Assumes: Prescale 0 ticks every cycle; load tallies high cycles.
// Notes: Windows span whole periods, except the 30- and 12-cycle ones, which start at a known phase.
`timescale 1ns/1ps

module tb_center_edge_pwm_channel
    import cpw_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic clear = 1'b0;
    logic [7:0] rd_data;
    logic pwm_out;
    logic [15:0] high_count;
    int n_mismatch = 0;
    int checks_done = 0;
    // channel at or past modulo gives full duty; values with the top bit set give none
    logic [15:0] ch_tab [4] = '{16'h0004, 16'h0005, 16'h8000, 16'hFFFF};
    logic [15:0] hi_tab [4] = '{16'h0020, 16'h0020, 16'h0000, 16'h0000};

    cpw_channel dut (.clock(clock), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .pwm_out(pwm_out));
    cpw_pwm_load load (.clock(clock), .clear(clear), .pwm_in(pwm_out),
        .high_count(high_count));

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr

    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 4'h1, v[7:0]);
    endtask : wr16

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        chk({8'h00, rd_data}, {8'h00, exp});
    endtask : rdc

    task automatic meas(input int pre, input int n, input logic [15:0] e);
        repeat (pre) @(posedge clock);
        @(posedge clock);
        clear <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        repeat (n) @(posedge clock);
        @(negedge clock);
        chk(high_count, e);
    endtask : meas

    task automatic complete_run;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        #500000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rdc(CPW_ADDR_CTRL, 8'h00);
        rdc(CPW_ADDR_MOD_L, 8'h00);
        rdc(CPW_ADDR_STATUS, 8'h00);
        rdc(4'hA, 8'h00);
        wr16(CPW_ADDR_MOD_H, 16'h0004);
        wr16(CPW_ADDR_CHV_H, 16'h0002);
        wr(CPW_ADDR_CTRL, 8'h28);
        meas(24, 32, 16'h0010);
        wr(CPW_ADDR_CTRL, 8'h20);
        wr(CPW_ADDR_CHV_L, 8'h03);
        rdc(CPW_ADDR_CHE_L, 8'h02);
        wr(CPW_ADDR_CTRL, 8'h28);
        meas(24, 32, 16'h0018);
        rdc(CPW_ADDR_CHE_L, 8'h03);
        for (int i = 0; i < 4; i++) begin
            wr16(CPW_ADDR_CHV_H, ch_tab[i]);
            meas(24, 32, hi_tab[i]);
        end
        // Halved prescale with doubled settings keeps the same waveform
        wr(CPW_ADDR_CTRL, 8'h29);
        wr16(CPW_ADDR_CHV_H, 16'h0002);
        meas(40, 32, 16'h0010);
        wr(CPW_ADDR_CTRL, 8'h28);
        wr16(CPW_ADDR_MOD_H, 16'h0008);
        wr16(CPW_ADDR_CHV_H, 16'h0004);
        meas(40, 32, 16'h0010);
        // Divide by two: 22 running cycles give 11 counts
        wr16(CPW_ADDR_MOD_H, 16'h0000);
        wr(CPW_ADDR_CTRL, 8'h01);
        wr(CPW_ADDR_CNT_L, 8'h00);
        rdc(CPW_ADDR_CNT_L, 8'h00);
        wr(CPW_ADDR_CTRL, 8'h09);
        repeat (20) @(posedge clock);
        wr(CPW_ADDR_CTRL, 8'h01);
        rdc(CPW_ADDR_CNT_L, 8'h0B);
        wr16(CPW_ADDR_MOD_H, 16'h0013);
        wr16(CPW_ADDR_CHV_H, 16'h0000);
        wr(CPW_ADDR_CTRL, 8'h08);
        meas(60, 20, 16'h0000);
        wr(CPW_ADDR_CTRL, 8'h00);
        wr(CPW_ADDR_CNT_L, 8'h00);
        wr(CPW_ADDR_CHV_L, 8'h02);
        wr(CPW_ADDR_CTRL, 8'h08);
        meas(0, 30, 16'h0000);
        meas(0, 40, 16'h0004);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rdc(CPW_ADDR_CTRL, 8'h00);
        rdc(CPW_ADDR_STATUS, 8'h00);
        // Known phase after reset: channel writes land mid-period
        wr16(CPW_ADDR_MOD_H, 16'h0004);
        wr(CPW_ADDR_CTRL, 8'h28);
        repeat (4) @(posedge clock);
        wr(CPW_ADDR_CHV_L, 8'h02);
        meas(0, 12, 16'h0004);
        repeat (3) @(posedge clock);
        wr(CPW_ADDR_CHV_L, 8'h00);
        meas(0, 16, 16'h0000);
        complete_run();
    end
endmodule : tb_center_edge_pwm_channel
